// ### ocad_pkg.sv
package ocad_pkg;

    // ************************************************************
    // Bus map
    // ************************************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_FRAG = 8'h08;
    localparam logic [7:0] ADR_DEVCTL = 8'h0C;
    localparam logic [7:0] ADR_ECOUNT = 8'h10;
    localparam logic [7:0] ADR_EINDEX = 8'h14;
    localparam logic [7:0] ADR_EDATA = 8'h18;
    localparam int CTRL_EN_BIT = 16;
    localparam int STAT_TOG_BIT = 8;
    localparam int STAT_RFRAG_BIT = 9;
    localparam int STAT_IFRAG_BIT = 10;
    localparam int STAT_LERR_BIT = 11;
    localparam logic [8:0] LEN_RST = 9'h108;
    localparam logic EN_RST = 1'b1;

    // ************************************************************
    // Output image layout
    // ************************************************************
    localparam logic [8:0] IMG_LEN_MIN = 9'h001;
    localparam logic [8:0] IMG_LEN_MAX = 9'h108;
    localparam logic [8:0] B_CTL = 9'h000;
    localparam logic [8:0] B_FNUM = 9'h001;
    localparam logic [8:0] B_FREM = 9'h002;
    localparam logic [8:0] B_FSIZE = 9'h003;
    localparam logic [8:0] B_TOG = 9'h004;
    localparam logic [8:0] B_DACL = 9'h005;
    localparam logic [8:0] B_DACH = 9'h006;
    localparam logic [8:0] B_ENTRY = 9'h009;
    localparam logic [7:0] ENTRY_LAST = 8'hFE;
    localparam int CTL_W = 5;
    localparam int CTL_ACT = 0;
    localparam int CTL_DRST = 2;
    localparam int TOG_POS = 6;

    // ************************************************************
    // Configuration image layout
    // ************************************************************
    localparam logic [2:0] CFG_LEN = 3'h4;
    localparam logic [2:0] CFG_B_RES = 3'h1;
    localparam logic [2:0] CFG_B_IN = 3'h2;
    localparam int CFG_EN_POS = 0;
    localparam logic CFG_RST = 1'b0;

    typedef enum logic [1:0] {
        OCAD_IDLE = 2'b00,
        OCAD_RECV = 2'b01,
        OCAD_SKIP = 2'b11
    } ocad_state_e;

endpackage : ocad_pkg

// ### ocad_edge.sv
`timescale 1ns/1ps
`default_nettype none
module ocad_edge
    import ocad_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic level,
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic prev;
        logic rise;
        logic fall;
    } ocad_edge_s;

    ocad_edge_s q, next_q;

    always_comb begin
        next_q = q;
        next_q.prev = level;
        next_q.rise = level & ~q.prev; // R13
        next_q.fall = ~level & q.prev; // R13
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign rise = q.rise;
    assign fall = q.fall;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_rise;
        !level ##1 level;
    endsequence
    sequence s_fall;
        level ##1 !level;
    endsequence

    a_rise_one_pulse: assert property (s_rise |=> rise ##1 !rise) // R13
        else $error("edge: rising edge not one pulse");
    a_fall_one_pulse: assert property (s_fall |=> fall ##1 !fall) // R13
        else $error("edge: falling edge not one pulse");

endmodule : ocad_edge
`default_nettype wire

// ### ocad_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module ocad_cfg
    import ocad_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic conn_setup,
    input wire logic cfg_valid,
    input wire logic cfg_first,
    input wire logic cfg_last,
    input wire logic [7:0] cfg_data,
    output logic res_frag_en,
    output logic in_frag_en,
    output logic cfg_done
);

    typedef struct packed {
        logic [2:0] idx;
        logic sres;
        logic sin;
        logic res;
        logic inp;
        logic done;
    } ocad_cfg_s;

    ocad_cfg_s q, next_q;
    logic [2:0] k;

    always_comb begin
        next_q = q;
        next_q.done = 1'b0;
        k = cfg_first ? 3'h0 : q.idx;
        // Bytes outside connection setup are ignored: not cyclic
        if (cfg_valid && conn_setup) begin // R9
            if (cfg_first) begin
                next_q.sres = CFG_RST;
                next_q.sin = CFG_RST;
            end
            if (k == CFG_B_RES) begin
                next_q.sres = cfg_data[CFG_EN_POS]; // R10 R14
            end
            if (k == CFG_B_IN) begin
                next_q.sin = cfg_data[CFG_EN_POS]; // R11 R14
            end
            if (k != 3'h7) begin
                next_q.idx = k + 3'h1;
            end
            if (cfg_last && (k + 3'h1 == CFG_LEN)) begin // R9
                next_q.res = next_q.sres;
                next_q.inp = next_q.sin;
                next_q.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '0; // R12
        end else begin
            q <= next_q;
        end
    end

    assign res_frag_en = q.res;
    assign in_frag_en = q.inp;
    assign cfg_done = q.done;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_cfg_default: assert property ( // R12
        $fell(sys_rst) |-> !res_frag_en && !in_frag_en)
        else $error("cfg: flags not cleared by reset");
    // Flags and the done pulse leave the same register edge
    a_cfg_only_setup: assert property ( // R9
        !cfg_done |-> $stable(res_frag_en) && $stable(in_frag_en))
        else $error("cfg: flag changed without a full image");
    a_cfg_needs_setup: assert property (cfg_done |-> $past(conn_setup)) // R9
        else $error("cfg: image taken outside setup");
    a_res_frag_set: assert property (cfg_done |-> res_frag_en == q.sres) // R10
        else $error("cfg: result fragmentation wrong");
    a_in_frag_set: assert property (cfg_done |-> in_frag_en == q.sin) // R11
        else $error("cfg: input fragmentation wrong");

endmodule : ocad_cfg
`default_nettype wire

// ### ocad_decoder.sv
// Notes on behaviour
// R1 - Output image length one to 264 bytes
// R2 - Byte 0: activation, ack, reset, error, standby
// R3 - Bytes 1-3: fragment number, remaining, size
// R4 - Byte 4 carries the new-entry toggle bit
// R5 - Bytes 5,6 form device control word
// R6 - Entry data bytes start at byte nine
// R7 - Controller sets length nine plus entries
// R8 - One-byte image carries only control bits
// R9 - Configuration image: four bytes, setup only
// R10 - Config byte 1 bit 0: result fragmentation
// R11 - Config byte 2 bit 0: input fragmentation
// R12 - Config defaults zero, fragmentation off
// R13 - Activation acts on its edges only
// R14 - Reserved bits ignored in both images
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ocad_decoder
    import ocad_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic img_valid,
    input wire logic img_first,
    input wire logic img_last,
    input wire logic [7:0] img_data,
    input wire logic conn_setup,
    input wire logic cfg_valid,
    input wire logic cfg_first,
    input wire logic cfg_last,
    input wire logic [7:0] cfg_data,
    output logic img_commit,
    output logic act_level,
    output logic acq_start,
    output logic acq_stop,
    output logic data_ack,
    output logic data_reset,
    output logic data_reset_pulse,
    output logic err_ack,
    output logic standby,
    output logic [7:0] frag_num,
    output logic [7:0] frag_remain,
    output logic [7:0] frag_size,
    output logic new_entry,
    output logic [15:0] dev_ctl,
    output logic [8:0] entry_count,
    output logic res_frag_en,
    output logic in_frag_en,
    output logic cfg_done
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        ocad_state_e st;
        logic [8:0] idx;
        logic [CTL_W-1:0] sctl;
        logic [7:0] sfnum;
        logic [7:0] sfrem;
        logic [7:0] sfsize;
        logic stog;
        logic [15:0] sdac;
        logic [CTL_W-1:0] ctl;
        logic [7:0] fnum;
        logic [7:0] frem;
        logic [7:0] fsize;
        logic tog;
        logic [15:0] dac;
        logic [8:0] ecnt;
        logic [254:0][7:0] ent;
        logic [8:0] len;
        logic en;
        logic len_err;
        logic commit;
        logic [7:0] eidx;
        logic ack;
        logic [31:0] rdat;
    } ocad_main_s;

    ocad_main_s q, next_q;
    logic [8:0] k;
    logic req;
    logic [31:0] rmux;
    logic [31:0] wmask;
    logic [31:0] wv;

    // ************************************************************
    // Register read mux
    // ************************************************************
    always_comb begin
        rmux = 32'h0000_0000;
        case (wb_adr_i)
            ADR_CTRL: begin
                rmux[8:0] = q.len;
                rmux[CTRL_EN_BIT] = q.en;
            end
            ADR_STATUS: begin
                rmux[CTL_W-1:0] = q.ctl;
                rmux[STAT_TOG_BIT] = q.tog;
                rmux[STAT_RFRAG_BIT] = res_frag_en;
                rmux[STAT_IFRAG_BIT] = in_frag_en;
                rmux[STAT_LERR_BIT] = q.len_err;
            end
            ADR_FRAG: begin
                rmux[23:0] = {q.fsize, q.frem, q.fnum};
            end
            ADR_DEVCTL: begin
                rmux[15:0] = q.dac;
            end
            ADR_ECOUNT: begin
                rmux[8:0] = q.ecnt;
            end
            ADR_EINDEX: begin
                rmux[7:0] = q.eidx;
            end
            ADR_EDATA: begin
                // Index 255 lies past the last entry and reads zero
                if (q.eidx <= ENTRY_LAST) begin
                    rmux[7:0] = q.ent[q.eidx];
                end
            end
            default: begin
                rmux = 32'h0000_0000;
            end
        endcase
    end

    assign req = wb_cyc_i & wb_stb_i & ~q.ack;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wv = (rmux & ~wmask) | (wb_dat_i & wmask);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_q = q;
        next_q.commit = 1'b0;
        next_q.ack = 1'b0;
        k = img_first ? 9'h000 : q.idx;
        // Bus first, so a frame error in the same cycle wins the clear
        if (req) begin
            next_q.ack = 1'b1;
            next_q.rdat = rmux;
            if (wb_we_i) begin
                case (wb_adr_i)
                    ADR_CTRL: begin
                        // Out-of-range lengths are refused, old kept
                        if (wv[8:0] >= IMG_LEN_MIN &&
                            wv[8:0] <= IMG_LEN_MAX) begin // R1
                            next_q.len = wv[8:0];
                        end
                        next_q.en = wv[CTRL_EN_BIT];
                    end
                    ADR_STATUS: begin
                        if (wv[STAT_LERR_BIT]) begin
                            next_q.len_err = 1'b0;
                        end
                    end
                    ADR_EINDEX: begin
                        next_q.eidx = wv[7:0];
                    end
                    default: begin
                        next_q.eidx = q.eidx;
                    end
                endcase
            end
        end
        if (img_valid) begin
            if (img_first) begin
                next_q.st = q.en ? OCAD_RECV : OCAD_SKIP;
                next_q.sctl = '0;
                next_q.sfnum = 8'h00;
                next_q.sfrem = 8'h00;
                next_q.sfsize = 8'h00;
                next_q.stog = 1'b0;
                next_q.sdac = 16'h0000;
            end
            if (next_q.st == OCAD_RECV) begin
                if (k < q.len) begin // R1
                    case (k)
                        B_CTL: next_q.sctl = img_data[CTL_W-1:0]; // R2 R14
                        B_FNUM: next_q.sfnum = img_data; // R3
                        B_FREM: next_q.sfrem = img_data; // R3
                        B_FSIZE: next_q.sfsize = img_data; // R3
                        B_TOG: next_q.stog = img_data[TOG_POS]; // R4 R14
                        B_DACL: next_q.sdac[7:0] = img_data; // R5
                        B_DACH: next_q.sdac[15:8] = img_data; // R5
                        default: begin
                            // Entries land in place; a dropped frame
                            // may leave some of them overwritten
                            if (k >= B_ENTRY) begin
                                next_q.ent[8'(k - B_ENTRY)] = img_data; // R6
                            end
                        end
                    endcase
                    next_q.idx = k + 9'h001;
                    if (img_last) begin
                        next_q.st = OCAD_IDLE;
                        if (k + 9'h001 == q.len) begin // R1 R7
                            next_q.ctl = next_q.sctl;
                            next_q.fnum = next_q.sfnum;
                            next_q.frem = next_q.sfrem;
                            next_q.fsize = next_q.sfsize;
                            next_q.tog = next_q.stog;
                            next_q.dac = next_q.sdac;
                            next_q.ecnt = (q.len > B_ENTRY) ?
                                q.len - B_ENTRY : 9'h000; // R6 R8
                            next_q.commit = 1'b1;
                        end else begin
                            next_q.len_err = 1'b1;
                        end
                    end
                end else begin
                    next_q.st = img_last ? OCAD_IDLE : OCAD_SKIP;
                    next_q.len_err = 1'b1;
                end
            end else if (img_last) begin
                next_q.st = OCAD_IDLE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '0;
            q.len <= LEN_RST;
            q.en <= EN_RST;
        end else begin
            q <= next_q;
        end
    end

    // ************************************************************
    // Edge decoders and configuration image
    // ************************************************************
    ocad_edge u_act_edge (
        .clock(clock),
        .sys_rst(sys_rst),
        .level(q.ctl[CTL_ACT]),
        .rise(acq_start),
        .fall(acq_stop)
    ); // R13

    ocad_edge u_drst_edge (
        .clock(clock),
        .sys_rst(sys_rst),
        .level(q.ctl[CTL_DRST]),
        .rise(data_reset_pulse),
        .fall()
    );

    ocad_cfg u_cfg (
        .clock(clock),
        .sys_rst(sys_rst),
        .conn_setup(conn_setup),
        .cfg_valid(cfg_valid),
        .cfg_first(cfg_first),
        .cfg_last(cfg_last),
        .cfg_data(cfg_data),
        .res_frag_en(res_frag_en),
        .in_frag_en(in_frag_en),
        .cfg_done(cfg_done)
    ); // R9 R10 R11 R12

    assign wb_dat_o = q.rdat;
    assign wb_ack_o = q.ack;
    assign img_commit = q.commit;
    assign act_level = q.ctl[0];
    assign data_ack = q.ctl[1];
    assign data_reset = q.ctl[2];
    assign err_ack = q.ctl[3];
    assign standby = q.ctl[4];
    assign frag_num = q.fnum;
    assign frag_remain = q.frem;
    assign frag_size = q.fsize;
    assign new_entry = q.tog;
    assign dev_ctl = q.dac;
    assign entry_count = q.ecnt;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_commit_length: assert property ( // R1
        img_commit |-> $past(k) + 9'h001 == q.len)
        else $error("dec: commit with wrong length");
    a_ctl_decode: assert property ( // R2
        img_commit && q.len == 9'h001 |-> q.ctl == $past(img_data[4:0]))
        else $error("dec: control bits wrong");
    a_short_image: assert property ( // R8
        img_commit && q.len == 9'h001 |-> entry_count == 9'h000 &&
        frag_num == 8'h00 && dev_ctl == 16'h0000)
        else $error("dec: one-byte image left fields");
    // Short images: the last byte taken is the field under test
    a_frag_fields: assert property ( // R3
        img_commit |-> (q.len != 9'h002 || frag_num == $past(img_data)) &&
        (q.len != 9'h003 || frag_remain == $past(img_data)) &&
        (q.len != 9'h004 || frag_size == $past(img_data)))
        else $error("dec: fragment fields wrong");
    a_toggle_bit: assert property ( // R4
        img_commit && q.len == 9'h005 |->
        new_entry == $past(img_data[TOG_POS]))
        else $error("dec: toggle bit wrong");
    a_dev_ctl_pair: assert property ( // R5
        img_commit && q.len == 9'h007 |-> dev_ctl[15:8] == $past(img_data))
        else $error("dec: device control word wrong");
    a_entry_count: assert property ( // R6
        img_commit && q.len > 9'h009 |-> entry_count == q.len - 9'h009)
        else $error("dec: entry count wrong");
    a_ctl_hold: assert property ( // R14
        !img_commit |=> $stable(q.ctl) || img_commit)
        else $error("dec: control changed without commit");
    a_bus_ack: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("dec: bus ack not one cycle");

endmodule : ocad_decoder
`default_nettype wire

// ### ocad_plc.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************
// Controller model: sends output and config images
// ********************************************
module ocad_plc (
    input wire logic clock,
    output logic img_valid,
    output logic img_first,
    output logic img_last,
    output logic [7:0] img_data,
    output logic conn_setup,
    output logic cfg_valid,
    output logic cfg_first,
    output logic cfg_last,
    output logic [7:0] cfg_data
);
    logic v, f, l, sel;
    logic [7:0] d;
    logic [7:0] q[$];

    initial begin
        v = 1'b0;
        f = 1'b0;
        l = 1'b0;
        sel = 1'b0;
        d = 8'h00;
        conn_setup = 1'b0;
    end

    // One shared byte lane, steered by the stream select
    assign img_valid = v & ~sel;
    assign cfg_valid = v & sel;
    assign img_first = f;
    assign cfg_first = f;
    assign img_last = l;
    assign cfg_last = l;
    assign img_data = d;
    assign cfg_data = d;

    // Setup is held by the caller; config goes out whether or not it is set
    task automatic set_conn(input logic lv);
        @(posedge clock);
        conn_setup <= lv;
    endtask : set_conn

    // Whole queue is one image; its size is the length sent
    task automatic send(input logic s, input int gap);
        for (int i = 0; i < q.size(); i++) begin
            @(posedge clock);
            sel <= s;
            v <= 1'b1;
            f <= (i == 0);
            l <= (i == q.size() - 1);
            d <= q[i];
            // Slow controller: lane shows junk between bytes
            repeat (gap) begin
                @(posedge clock);
                v <= 1'b0;
                d <= ~q[i];
            end
        end
        @(posedge clock);
        v <= 1'b0;
        d <= ~d;
    endtask : send
endmodule : ocad_plc
`default_nettype wire

// ### ocad_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ocad_decoder_bench
    import ocad_pkg::*;
;
    logic clock, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic img_valid, img_first, img_last, conn_setup;
    logic cfg_valid, cfg_first, cfg_last, img_commit, act_level;
    logic [7:0] img_data, cfg_data, frag_num, frag_remain, frag_size;
    logic acq_start, acq_stop, data_ack, data_reset, data_reset_pulse;
    logic err_ack, standby, new_entry, res_frag_en, in_frag_en, cfg_done;
    logic [15:0] dev_ctl;
    logic [8:0] entry_count;
    logic [7:0] b[$];
    int miscompares = 0;
    int tests_run = 0;
    int seed = 32'hde99;
    int n_start = 0, n_stop = 0, n_drp = 0, n_com = 0, n_cfg = 0;
    int e_start = 0, e_stop = 0, e_drp = 0, e_cfg = 0;
    int pact = 0, pdrp = 0, er = 0, ei = 0;
    logic en_img = 1'b1;
    int lens[11] = '{1, 2, 4, 5, 7, 9, 10, 19, 264, 264, 3};

    ocad_decoder i_dut (.*);
    ocad_plc i_plc (.*);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        n_start <= n_start + int'(acq_start);
        n_stop <= n_stop + int'(acq_stop);
        n_drp <= n_drp + int'(data_reset_pulse);
        n_com <= n_com + int'(img_commit);
        n_cfg <= n_cfg + int'(cfg_done);
    end

    // ********************************************
    // Shared tasks
    // ********************************************
    task automatic check(input string nm, input logic [31:0] exp,
        input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic finish_test;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // Classic cycle; read data taken at the edge that sees ack high
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] dt);
        int t;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= dt;
        t = 0;
        do begin
            @(posedge clock);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (t >= 50) begin
            miscompares++;
        end
    endtask : wb

    function automatic logic [7:0] g(input int k);
        return (k < b.size()) ? b[k] : 8'h00;
    endfunction : g

    // ********************************************
    // Image and config scenarios against the model
    // ********************************************
    task automatic run_img(input int len, input int n, input int gap);
        int c0;
        logic a;
        logic [7:0] t4;
        b.delete();
        for (int k = 0; k < n; k++) begin
            b.push_back(8'($random(seed)));
        end
        wb(1'b1, ADR_CTRL, {15'h0000, en_img, 7'h00, 9'(len)});
        i_plc.q = b;
        c0 = n_com;
        i_plc.send(1'b0, gap);
        repeat (3) @(negedge clock);
        // With acceptance off an image is dropped without an error
        if (n != len || !en_img) begin
            check("no_commit", 0, n_com - c0);
            wb(1'b0, ADR_STATUS, 32'h0);
            check("len_err", 32'(en_img), 32'(rd[STAT_LERR_BIT]));
            wb(1'b1, ADR_STATUS, 32'h0000_0800);
            return;
        end
        t4 = g(4);
        a = b[0][CTL_ACT];
        if (a && pact == 0) e_start++;
        if (!a && pact == 1) e_stop++;
        if (b[0][CTL_DRST] && pdrp == 0) e_drp++;
        pact = int'(a);
        pdrp = int'(b[0][CTL_DRST]);
        check("commit", 1, n_com - c0);
        check("ctl", 32'(b[0][4:0]), 32'({standby, err_ack, data_reset,
            data_ack, act_level}));
        check("frag", {8'h00, g(3), g(2), g(1)},
            {8'h00, frag_size, frag_remain, frag_num});
        check("toggle", 32'(t4[TOG_POS]), 32'(new_entry));
        check("devctl", {16'h0000, g(6), g(5)}, 32'(dev_ctl));
        check("ecount", (n > 9) ? n - 9 : 0, 32'(entry_count));
        check("starts", e_start, n_start);
        check("stops", e_stop, n_stop);
        check("drst", e_drp, n_drp);
        wb(1'b0, ADR_STATUS, 32'h0);
        check("st_ctl", 32'({t4[TOG_POS], 3'h0, b[0][4:0]}),
            32'(rd[8:0]));
        for (int k = 0; k < n - 9; k += n - 10) begin
            wb(1'b1, ADR_EINDEX, 32'(k));
            wb(1'b0, ADR_EDATA, 32'h0);
            check("entry", 32'(b[9 + k]), 32'(rd[7:0]));
            if (n == 10) break;
        end
    endtask : run_img

    task automatic run_cfg(input int n, input logic s, input logic r,
        input logic i);
        b.delete();
        for (int k = 0; k < 4; k++) begin
            b.push_back(8'($random(seed)));
        end
        b[1][0] = r;
        b[2][0] = i;
        while (b.size() > n) void'(b.pop_back());
        i_plc.set_conn(s);
        i_plc.q = b;
        i_plc.send(1'b1, 0);
        repeat (3) @(negedge clock);
        i_plc.set_conn(1'b0);
        if (s && n == 4) begin
            er = int'(r);
            ei = int'(i);
            e_cfg++;
        end
        check("cfg_cnt", e_cfg, n_cfg);
        check("res_frag", er, 32'(res_frag_en));
        check("in_frag", ei, 32'(in_frag_en));
    endtask : run_cfg

    initial begin
        sys_rst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        check("rst_frag", 0, 32'({res_frag_en, in_frag_en}));
        wb(1'b0, ADR_CTRL, 32'h0);
        check("ctrl_rst", {15'h0000, EN_RST, 7'h00, LEN_RST}, rd);
        wb(1'b0, 8'h40, 32'h0);
        check("unmapped", 0, rd);
        $display("test reset done");
        run_cfg(4, 1'b1, 1'b1, 1'b0);
        run_cfg(4, 1'b1, 1'b0, 1'b1);
        run_cfg(4, 1'b0, 1'b1, 1'b1);
        run_cfg(3, 1'b1, 1'b1, 1'b0);
        run_cfg(4, 1'b1, 1'b1, 1'b1);
        $display("test config done");
        for (int k = 0; k < 12; k++) run_img(1, 1, k % 2);
        foreach (lens[k]) run_img(lens[k], lens[k], $random(seed) & 1);
        $display("test images done");
        run_img(10, 9, 0);
        run_img(10, 11, 1);
        run_img(1, 2, 0);
        run_img(264, 264, 0);
        en_img = 1'b0;
        run_img(19, 19, 0);
        en_img = 1'b1;
        $display("test length errors done");
        finish_test;
    end

    initial begin
        #(20000 * 100);
        miscompares++;
        finish_test;
    end
endmodule : ocad_decoder_bench
`default_nettype wire
